// ===== watchdog_change_protect_prescaler_tb_top.sv
/* Top bench of the watchdog control block: register sequences with expected values.
   Assumes wdcp_top with a base count of 4 and the software model beside it. */
`timescale 1ns/10ps
`default_nettype none
module watchdog_change_protect_prescaler_tb_top
    import wdcp_pkg::*;
;
    localparam int         BASE = 4;
    localparam logic [7:0] CTL  = WDCP_ADDR_CONTROL;
    localparam logic [7:0] CAU  = WDCP_ADDR_CAUSE;
    localparam logic [7:0] STA  = WDCP_ADDR_IRQ_STAT;
    localparam logic [7:0] MSK  = WDCP_ADDR_IRQ_MASK;
    localparam logic [7:0] CMD  = WDCP_ADDR_COMMAND;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        always_on_fuse = 1'b0;
    logic        vector_taken = 1'b0;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        wd_osc;
    logic        timeout_vector_req;
    logic        wd_reset_req;
    logic [15:0] reset_vector_addr;
    logic        irq;
    logic [31:0] rdv;
    int          t;
    int          miscompares = 0;
    int          checks_done = 0;

    always #50 sys_clk = ~sys_clk;

    wdcp_top #(.BASE_CYCLES(BASE)) i_wdcp_top (.*);
    wdcp_sw_model i_wdcp_sw_model (.*);

    // ****************
    // Helpers
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        i_wdcp_sw_model.wr(a, d);
    endtask : w
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        i_wdcp_sw_model.rd(a, rdv);
        check(rdv, {24'h000000, exp});
    endtask : rdc
    // Waits for reset request (0), irq (1) or vector request (2), bounded
    task automatic await(input int which);
        t = 0;
        do begin
            @(negedge sys_clk);
            t++;
        end while (!(which == 0 ? wd_reset_req === 1'b1 : which == 1 ? irq === 1'b1
                     : timeout_vector_req === 1'b1) && t < 400);
        check(32'(t < 400), 32'h00000001);
    endtask : await
    task automatic pulse();
        @(posedge sys_clk);
        vector_taken <= 1'b1;
        @(posedge sys_clk);
        vector_taken <= 1'b0;
    endtask : pulse
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // ****************
    // Sequences
    // ****************
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdc(CTL, 8'h00);
        rdc(CAU, 8'h00);
        rdc(8'h20, 8'h00);
        rdc(WDCP_ADDR_VECTOR, 8'h00);
        check({16'h0000, reset_vector_addr}, 32'h0);
        i_wdcp_sw_model.wr(CTL, 8'h08, 4'hE);
        rdc(CTL, 8'h00);
        w(CTL, 8'h05);
        rdc(CTL, 8'h00);
        w(CTL, 8'h18);
        w(CTL, 8'h21);
        rdc(CTL, 8'h21);
        w(CTL, 8'h18);
        w(CTL, 8'h03);
        rdc(CTL, 8'h03);
        // Last edge of the change window still accepts the protected write
        w(CTL, 8'h18);
        @(posedge sys_clk);
        w(CTL, 8'h03);
        rdc(CTL, 8'h03);
        w(CTL, 8'h1B);
        rdc(CTL, 8'h1B);
        repeat (6) @(posedge sys_clk);
        w(CTL, 8'h00);
        rdc(CTL, 8'h0B);
        // One edge later the window has shut
        w(CTL, 8'h1B);
        repeat (2) @(posedge sys_clk);
        w(CTL, 8'h03);
        rdc(CTL, 8'h0B);
        // Reset mode: masked event first, then period of 32 ticks of 4 cycles
        await(0);
        check({31'h0, irq}, 32'h0);
        w(MSK, 8'h02);
        await(0);
        check(32'(t > 125 && t < 131), 32'h00000001);
        check({31'h0, irq}, 32'h1);
        w(CMD, 8'h01);
        rdc(CAU, 8'h08);
        rdc(STA, 8'h02);
        w(CTL, 8'h1B);
        w(CTL, 8'h03);
        rdc(CTL, 8'h0B);
        w(CAU, 8'h00);
        w(CTL, 8'h1B);
        w(CTL, 8'h03);
        rdc(CTL, 8'h03);
        w(STA, 8'h02);
        repeat (2) @(negedge sys_clk);
        check({31'h0, irq}, 32'h0);
        // Stopped mode: a long wait raises no event
        repeat (200) @(negedge sys_clk);
        rdc(STA, 8'h00);
        rdc(CAU, 8'h00);
        // Interrupt mode
        w(MSK, 8'h01);
        w(CTL, 8'h1B);
        w(CTL, 8'h43);
        await(1);
        check({31'h0, timeout_vector_req}, 32'h1);
        rdc(CTL, 8'hC3);
        w(STA, 8'h01);
        repeat (2) @(negedge sys_clk);
        check({31'h0, irq}, 32'h0);
        w(CTL, 8'hC3);
        rdc(CTL, 8'h43);
        await(2);
        pulse();
        rdc(CTL, 8'h43);
        // Combined mode: vector drops enable, next time-out resets
        w(CTL, 8'h1B);
        w(CTL, 8'h4B);
        await(2);
        pulse();
        rdc(CTL, 8'h0B);
        await(0);
        w(CMD, 8'h01);
        w(CAU, 8'h00);
        w(CTL, 8'h1B);
        w(CTL, 8'h03);
        rdc(CTL, 8'h03);
        // Programmed fuse locks reset mode
        always_on_fuse <= 1'b1;
        repeat (4) @(posedge sys_clk);
        w(CTL, 8'h18);
        w(CTL, 8'h40);
        rdc(CTL, 8'h08);
        await(0);
        check({31'h0, timeout_vector_req}, 32'h0);
        conclude();
    end

    initial begin
        repeat (3000) @(posedge sys_clk);
        miscompares++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        conclude();
    end
endmodule : watchdog_change_protect_prescaler_tb_top
`default_nettype wire

// ===== wdcp_pkg.sv
/*
 * Shared constants of the watchdog control block: register offsets, bit positions,
 * reset values, prescaler limits and mode encodings.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses and one word per register.
 */
`default_nettype none
package wdcp_pkg;
    // ************************************************
    // Register map (byte addresses)
    // ************************************************
    localparam logic [7:0] WDCP_ADDR_CONTROL  = 8'h00;
    localparam logic [7:0] WDCP_ADDR_CAUSE    = 8'h04;
    localparam logic [7:0] WDCP_ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] WDCP_ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] WDCP_ADDR_COMMAND  = 8'h10;
    localparam logic [7:0] WDCP_ADDR_VECTOR   = 8'h14;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int CTL_IRQ_FLAG   = 7;
    localparam int CTL_IRQ_EN     = 6;
    localparam int CTL_SEL_MSB    = 5;
    localparam int CTL_CHG_EN     = 4;
    localparam int CTL_SRE        = 3;
    localparam int CTL_SEL_LO_TOP = 2;
    localparam int CAUSE_WD_FLAG  = 3;
    localparam int IRQ_TIMEOUT    = 0;
    localparam int IRQ_WD_RESET   = 1;
    localparam int CMD_RESTART    = 0;
    localparam int CMD_VECTOR_ACK = 1;

    localparam int WDCP_IRQ_BITS = 2;

    // ************************************************
    // Reset values and timing
    // ************************************************
    localparam logic [3:0]  WDCP_SEL_RESET     = 4'h0;
    localparam logic [2:0]  WDCP_CHG_WINDOW    = 3'h4;
    localparam logic [15:0] WDCP_RESET_VECTOR  = 16'h0000;
    localparam logic [3:0]  WDCP_SEL_LAST      = 4'h9;
    localparam int          WDCP_BASE_CYCLES   = 2048;
    localparam int          WDCP_BASE_MS       = 16;
    localparam int          WDCP_CNT_W         = 21;

    typedef enum logic [1:0] {
        WDCP_STOPPED   = 2'b00,
        WDCP_IRQ_MODE  = 2'b01,
        WDCP_RST_MODE  = 2'b10,
        WDCP_BOTH_MODE = 2'b11
    } wdcp_mode_e;
endpackage : wdcp_pkg
`default_nettype wire

// ===== wdcp_sw_model.sv
/* Software side of the watchdog block: Avalon-MM master tasks and the
   free-running watchdog oscillator. Assumes a waitrequest slave on sys_clk. */
`timescale 1ns/10ps
`default_nettype none
module wdcp_sw_model (
    input  wire logic        sys_clk,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    output logic             wd_osc
);
    logic [1:0] osc_div;
    initial begin
        osc_div        = 2'h0;
        avs_address    = 8'hFF;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'hFFFFFFFF;
        avs_byteenable = 4'hF;
    end
    // Quarter-rate oscillator; runs free as the real one does
    always @(posedge sys_clk) begin
        osc_div <= osc_div + 2'h1;
    end
    assign wd_osc = osc_div[1];

    // Released lines show the inverse so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be = 4'hF);
        @(posedge sys_clk);
        avs_address    <= a;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write     <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= ~{24'h000000, d};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        avs_address    <= a;
        avs_byteenable <= 4'hF;
        avs_read       <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read    <= 1'b0;
        avs_address <= ~a;
    endtask : rd
endmodule : wdcp_sw_model
`default_nettype wire

// ===== wdcp_tick_counter.sv
/*
 * Time-out counter of the watchdog: counts ticks of the watchdog oscillator and
 * flags a time-out after the number of ticks selected by the prescaler code.
 * Assumes tick is a one-cycle pulse already synchronised to sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module wdcp_tick_counter
    import wdcp_pkg::*;
#(
    parameter int BASE_CYCLES = WDCP_BASE_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [3:0] sel,
    output logic            timeout
);
    logic [WDCP_CNT_W-1:0] count;
    logic [WDCP_CNT_W-1:0] limit;
    logic [3:0]            sel_eff;

    // Reserved codes fall back to the longest period
    assign sel_eff = (sel > WDCP_SEL_LAST) ? WDCP_SEL_LAST : sel;
    assign limit   = WDCP_CNT_W'(BASE_CYCLES) << sel_eff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count   <= '0;
            timeout <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (!run || restart) begin
                count <= '0;
            end else if (tick) begin
                // Shrinking the period below the count expires at the next tick
                if (count >= limit - WDCP_CNT_W'(1)) begin
                    count   <= '0;
                    timeout <= 1'b1;
                end else begin
                    count <= count + WDCP_CNT_W'(1);
                end
            end
        end
    end
endmodule : wdcp_tick_counter
`default_nettype wire

// ===== wdcp_top.sv
/*
 * Watchdog control block: protected control register, forced reset enable,
 * prescaled time-out on the watchdog oscillator, mode selection and interrupts.
 * Assumes an Avalon-MM master on sys_clk, a free-running watchdog oscillator pin,
 * a fuse strap level and a CPU pulse marking execution of the time-out vector.
 */
// What this block does
// - Clearing reset enable or changing prescaler only works while change enable set
// - Change enable clears itself four system clock cycles after being written one
// - Watchdog reset flag set forces reset enable to read and act as one
// - Prescaler select bit 3 sits at bit 5, bits 2..0 at bits 2..0
// - Codes 0 to 9 select 2048 cycles doubled per step, up to 1048576
// - Time-out counts watchdog oscillator cycles, 16ms nominal up to 8.2s
// - Watchdog reset restarts execution at shared reset vector address 0x0000
// - Unfused: enable bits select stopped, interrupt, reset, or interrupt-then-reset
// - Fuse programmed forces reset mode: reset enable one, interrupt enable zero
// - Time-out with interrupt enable sets interrupt flag; vector or write-one clears; combined clears enable
`timescale 1ns/10ps
`default_nettype none
module wdcp_top
    import wdcp_pkg::*;
#(
    parameter int BASE_CYCLES = WDCP_BASE_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        wd_osc,
    input  wire logic        always_on_fuse,
    input  wire logic        vector_taken,
    output logic             timeout_vector_req,
    output logic             wd_reset_req,
    output logic      [15:0] reset_vector_addr,
    output logic             irq
);
    // ************************************************
    // Input synchronisers
    // ************************************************
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic fuse_meta;
    logic fuse_sync;
    logic osc_tick;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= wd_osc;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fuse_meta <= 1'b0;
            fuse_sync <= 1'b0;
        end else begin
            fuse_meta <= always_on_fuse;
            fuse_sync <= fuse_meta;
        end
    end

    assign osc_tick = osc_sync & ~osc_prev;

    // ************************************************
    // Bus slave: one wait cycle, then the transfer completes
    // ************************************************
    logic       bus_req;
    logic       wr_take;
    logic       lane0;
    logic [7:0] wdata;

    assign bus_req = avs_read | avs_write;
    assign wr_take = avs_write & ~avs_waitrequest;
    assign lane0   = avs_byteenable[0];
    assign wdata   = avs_writedata[7:0];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    logic wr_ctl;
    logic wr_cause;
    logic wr_stat;
    logic wr_mask;
    logic wr_cmd;

    assign wr_ctl   = wr_take && lane0 && avs_address == WDCP_ADDR_CONTROL;
    assign wr_cause = wr_take && lane0 && avs_address == WDCP_ADDR_CAUSE;
    assign wr_stat  = wr_take && lane0 && avs_address == WDCP_ADDR_IRQ_STAT;
    assign wr_mask  = wr_take && lane0 && avs_address == WDCP_ADDR_IRQ_MASK;
    assign wr_cmd   = wr_take && lane0 && avs_address == WDCP_ADDR_COMMAND;

    // ************************************************
    // Control register state
    // ************************************************
    logic       sre_stored;
    logic       irq_en_stored;
    logic [3:0] sel;
    logic       chg_en;
    logic [2:0] chg_count;
    logic       irq_flag;
    logic       wd_flag;
    logic       sre_eff;
    logic       irq_en_eff;
    logic [3:0] sel_written;
    logic       timeout;
    logic       vector_clear;
    logic       irq_set;
    logic       rst_fire;
    wdcp_mode_e mode;

    assign sel_written = {wdata[CTL_SEL_MSB], wdata[CTL_SEL_LO_TOP:0]};
    assign sre_eff     = sre_stored | wd_flag | fuse_sync;
    assign irq_en_eff  = irq_en_stored & ~fuse_sync;
    assign mode        = wdcp_mode_e'({sre_eff, irq_en_eff});

    // Change-enable window; a new write of one restarts it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            chg_en    <= 1'b0;
            chg_count <= '0;
        end else if (wr_ctl && wdata[CTL_CHG_EN]) begin
            chg_en    <= 1'b1;
            chg_count <= WDCP_CHG_WINDOW;
        end else if (wr_ctl) begin
            chg_en    <= 1'b0;
            chg_count <= '0;
        end else if (chg_count > 3'h1) begin
            chg_count <= chg_count - 3'h1;
        end else begin
            chg_en    <= 1'b0;
            chg_count <= '0;
        end
    end

    // Setting reset enable is always allowed; clearing it needs the window
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sre_stored <= 1'b0;
        end else if (wr_ctl && wdata[CTL_SRE]) begin
            sre_stored <= 1'b1;
        end else if (wr_ctl && chg_en) begin
            sre_stored <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel <= WDCP_SEL_RESET;
        end else if (wr_ctl && chg_en) begin
            sel <= sel_written;
        end
    end

    // Vector execution in combined mode drops to plain reset mode
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_en_stored <= 1'b0;
        end else if (vector_clear && sre_eff) begin
            irq_en_stored <= 1'b0;
        end else if (wr_ctl) begin
            irq_en_stored <= wdata[CTL_IRQ_EN];
        end
    end

    assign vector_clear = vector_taken & timeout_vector_req;

    // ************************************************
    // Time-out handling per mode
    // ************************************************
    wdcp_tick_counter #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_counter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tick    (osc_tick),
        .run     (mode != WDCP_STOPPED),
        .restart (wr_cmd && wdata[CMD_RESTART] || wd_reset_req),
        .sel     (sel),
        .timeout (timeout)
    );

    always_comb begin
        irq_set  = 1'b0;
        rst_fire = 1'b0;
        case (mode)
            WDCP_STOPPED: begin
                irq_set  = 1'b0;
            end
            WDCP_IRQ_MODE: begin
                irq_set  = timeout;
            end
            WDCP_RST_MODE: begin
                rst_fire = timeout;
            end
            WDCP_BOTH_MODE: begin
                // Second time-out with the vector still pending resets
                irq_set  = timeout & ~irq_flag;
                rst_fire = timeout & irq_flag;
            end
            default: begin
                irq_set  = 1'b0;
            end
        endcase
    end

    // Set wins over both clears
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_flag <= 1'b0;
        end else if (irq_set) begin
            irq_flag <= 1'b1;
        end else if (vector_clear || (wr_ctl && wdata[CTL_IRQ_FLAG])) begin
            irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_flag <= 1'b0;
        end else if (rst_fire) begin
            wd_flag <= 1'b1;
        end else if (wr_cause && !wdata[CAUSE_WD_FLAG]) begin
            wd_flag <= 1'b0;
        end
    end

    // ************************************************
    // Reset request and vector
    // ************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_reset_req      <= 1'b0;
            reset_vector_addr <= WDCP_RESET_VECTOR;
        end else begin
            wd_reset_req      <= rst_fire;
            reset_vector_addr <= WDCP_RESET_VECTOR;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timeout_vector_req <= 1'b0;
        end else begin
            timeout_vector_req <= (irq_flag | irq_set) & irq_en_eff & ~vector_clear;
        end
    end

    // ************************************************
    // Interrupt status and mask
    // ************************************************
    logic [WDCP_IRQ_BITS-1:0] irq_stat;
    logic [WDCP_IRQ_BITS-1:0] irq_mask;
    logic [WDCP_IRQ_BITS-1:0] irq_event;

    assign irq_event[IRQ_TIMEOUT]  = irq_set;
    assign irq_event[IRQ_WD_RESET] = rst_fire;

    generate
        for (genvar i = 0; i < WDCP_IRQ_BITS; i++) begin : g_stat
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    irq_stat[i] <= 1'b0;
                end else if (irq_event[i]) begin
                    irq_stat[i] <= 1'b1;
                end else if (wr_stat && wdata[i]) begin
                    irq_stat[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= wdata[WDCP_IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ************************************************
    // Read data, captured in the wait cycle
    // ************************************************
    logic [7:0] ctl_view;
    logic [7:0] next_rdata;

    always_comb begin
        ctl_view                 = '0;
        ctl_view[CTL_IRQ_FLAG]   = irq_flag;
        ctl_view[CTL_IRQ_EN]     = irq_en_eff;
        ctl_view[CTL_SEL_MSB]    = sel[3];
        ctl_view[CTL_CHG_EN]     = chg_en;
        ctl_view[CTL_SRE]        = sre_eff;
        ctl_view[CTL_SEL_LO_TOP:0] = sel[2:0];
    end

    always_comb begin
        next_rdata = '0;
        case (avs_address)
            WDCP_ADDR_CONTROL:  next_rdata = ctl_view;
            WDCP_ADDR_CAUSE:    next_rdata[CAUSE_WD_FLAG] = wd_flag;
            WDCP_ADDR_IRQ_STAT: next_rdata[WDCP_IRQ_BITS-1:0] = irq_stat;
            WDCP_ADDR_IRQ_MASK: next_rdata[WDCP_IRQ_BITS-1:0] = irq_mask;
            WDCP_ADDR_VECTOR:   next_rdata = reset_vector_addr[7:0];
            default:            next_rdata = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h000000, next_rdata};
        end
    end
endmodule : wdcp_top
`default_nettype wire

// ===== wdcp_top_asserts.sv
/* Concurrent checks on the ports of the watchdog control block.
   Assumes bind into wdcp_top and one clock domain, sys_clk. */
`timescale 1ns/10ps
`default_nettype none
module wdcp_top_checker
    import wdcp_pkg::*;
#(
    parameter int BASE_CYCLES = WDCP_BASE_CYCLES
) (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        wd_osc,
    input wire logic        always_on_fuse,
    input wire logic        vector_taken,
    input wire logic        timeout_vector_req,
    input wire logic        wd_reset_req,
    input wire logic [15:0] reset_vector_addr,
    input wire logic        irq
);
    // ****************
    // Oscillator edges since last reset request
    // ****************
    // Raw edges lead the synchronised count, so this only gives a floor
    logic osc_q;
    int   osc_ticks;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_q     <= 1'b0;
            osc_ticks <= 0;
        end else begin
            osc_q <= wd_osc;
            if (wd_reset_req) begin
                osc_ticks <= 0;
            end else if (wd_osc && !osc_q) begin
                osc_ticks <= osc_ticks + 1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_answer_next: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h14
        |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_vector_fixed: assert property (reset_vector_addr == WDCP_RESET_VECTOR)
        else $error("reset vector not zero");
    a_reset_pulse: assert property (wd_reset_req |=> !wd_reset_req)
        else $error("reset request longer than one cycle");
    a_period_floor: assert property (wd_reset_req |-> osc_ticks >= BASE_CYCLES - 1)
        else $error("time-out before the base count of ticks");
    a_fuse_no_vec: assert property (always_on_fuse [*4] |-> !timeout_vector_req)
        else $error("vector request while fuse programmed");
    a_vector_clear: assert property (vector_taken && timeout_vector_req
        |=> ##[0:1] !timeout_vector_req)
        else $error("vector request not cleared by vector");
    a_irq_by_write: assert property ($fell(irq) |-> $past(avs_write && !avs_waitrequest)
        || $past(avs_write && !avs_waitrequest, 2))
        else $error("irq dropped without a register write");
endmodule : wdcp_top_checker

bind wdcp_top wdcp_top_checker #(.BASE_CYCLES(BASE_CYCLES)) i_wdcp_top_checker (.*);
`default_nettype wire
